// ==== include/sps_pin_map.svh ====
/*
 * Constants for the shared-pin serial front end: rate codes, clock codes,
 * channel limits and frame pulse detection counts.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef SPS_PIN_MAP_SVH
`define SPS_PIN_MAP_SVH

// ----------------------------------------------------------------------
// Stream rate and clock speed codes
// ----------------------------------------------------------------------
`define SPS_RATE_2M 2'h0
`define SPS_RATE_4M 2'h1
`define SPS_RATE_8M 2'h2
`define SPS_CLK_4M 1'b0
`define SPS_CLK_8M 1'b1

// ----------------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------------
`define SPS_LAST_CH_2M 7'h1f
`define SPS_LAST_CH_4M 7'h3f
`define SPS_LAST_CH_8M 7'h7f
`define SPS_BIT_LAST 3'h7
`define SPS_NUM_STREAMS 14
`define SPS_NUM_MAIN 8

// ----------------------------------------------------------------------
// Frame pulse polarity detection
// ----------------------------------------------------------------------
`define SPS_FP_STABLE 4'h8

`endif

// ==== include/sps_pin_pkg.sv ====
/*
 * Types for the shared-pin serial front end.
 * Assumes sps_pin_map.svh is on the include path.
 */
package sps_pin_pkg;
`include "sps_pin_map.svh"

   // -------------------------------------------------------------------
   // Frame pulse detector states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      FP_SEEK,
      FP_IDLE,
      FP_PULSE
   } sps_fp_state_t;

   typedef logic [1:0] sps_rate_t;
endpackage

// ==== verilog/sps_pin_front.sv ====
/*
 * Front-end pin logic of a multiple-rate time-slot switch: role decode of
 * shared serial/address pins, frame pulse detection, serial sampling on
 * the link clock and the open-drain transfer acknowledge.
 * Assumes configuration inputs come from CLK-domain control logic, serial
 * data is launched on SER_CLK, and the pad ring resolves open-drain pins.
 */
// What this block does
// RULE_01: Pull transfer acknowledge low when a bus transfer finishes, else release.
// RULE_02: Streams carry 32, 64 or 128 channels at 2.048, 4.096, 8.192 Mb/s.
// RULE_03: Non-multiplexed bus at 8.192 or 4.096 Mb/s makes input-6 pin address 6.
// RULE_04: At 2.048, 4.096 eight-by-four, or multiplexed bus, input-6 pin is stream 6.
// RULE_05: Non-multiplexed bus at 8.192 Mb/s makes input-7 pin address bit 7.
// RULE_06: At 2.048, 4.096 eight-by-four, or multiplexed bus, input-7 pin is stream 7.
// RULE_07: Accept either frame pulse polarity and detect which one arrives.
// RULE_08: Serial clock is 4.096 or 8.192 MHz, chosen by interface speed.
// RULE_09: Non-multiplexed bus uses the three lowest shared pins as address 0-2.
// RULE_10: Sixteen-by-eight mode uses address 0-2 pins as 2.048 Mb/s streams 8-10.
// RULE_11: Address 3-5 pins are address bits or, in 16x8, streams 11-13.
// RULE_12: The processor asserts chip select low for every access.
// RULE_13: Sample bits on the serial clock; channels restart at each frame pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sps_pin_map.svh"

module sps_pin_front
   import sps_pin_pkg::*;
(
   // System clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Link clock and frame pulse
   input wire logic SER_CLK,
   input wire logic FRAME_SYNC_PULSE,
   // Shared and dedicated pins
   input wire logic [5:0] SERIAL_IN_0_TO_5,
   input wire logic SERIAL_IN6_OR_ADDR6,
   input wire logic SERIAL_IN7_OR_ADDR7,
   input wire logic [2:0] ADDR_LOW_OR_SERIAL_IN_8_10,
   input wire logic [2:0] ADDR_MID_OR_SERIAL_IN_11_13,
   // Configuration from the interface mode and control logic
   input wire logic MUX_BUS_SEL,
   input wire logic [1:0] STREAM_RATE,
   input wire logic CLK_SPEED_SEL,
   input wire logic CFG_8X4,
   input wire logic CFG_16X8,
   // Processor handshake
   input wire logic CHIP_SELECT_N,
   input wire logic XFER_DONE,
   output logic TRANSFER_ACK_N_OUT,
   output logic TRANSFER_ACK_N_OE,
   // Decoded address pins
   output logic [7:0] ADDR_BUS,
   output logic [7:0] ADDR_VALID,
   output logic [13:0] STREAM_ACTIVE,
   // Received channel bytes, group 0 = streams 0-7, group 1 = 8-13
   output logic [111:0] RX_DATA,
   output logic [13:0] RX_CHAN,
   output logic [1:0] RX_VALID,
   output logic GCI_MODE
);

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   // Log2 of serial clocks per bit; clamps at one clock per bit
   function automatic logic [1:0] bit_span(input logic clk8,
                                           input sps_rate_t rate);
      logic [2:0] s;
      s = {2'h0, clk8} + 3'h1;
      if (s > {1'b0, rate})
         bit_span = 2'(s - {1'b0, rate});
      else
         bit_span = 2'h0;
   endfunction

   function automatic logic [6:0] last_chan(input sps_rate_t rate);
      unique case (rate)
         `SPS_RATE_8M: last_chan = `SPS_LAST_CH_8M;
         `SPS_RATE_4M: last_chan = `SPS_LAST_CH_4M;
         default: last_chan = `SPS_LAST_CH_2M;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Pin role decode (CLK domain)
   // ------------------------------------------------------------------
   logic [7:0] next_addr_valid;
   logic [13:0] pin_raw;
   logic [13:0] pin_s1;
   logic [13:0] pin_s2;
   logic cs_s1;
   logic cs_s2;

   always_comb begin
      next_addr_valid = 8'h00;
      if (!MUX_BUS_SEL && !CFG_16X8) begin
         next_addr_valid[5:0] = 6'h3f;  // [RULE_09] [RULE_11]
      end
      if (!MUX_BUS_SEL && !CFG_8X4 &&
          (STREAM_RATE == `SPS_RATE_8M ||
           STREAM_RATE == `SPS_RATE_4M)) begin
         next_addr_valid[6] = 1'b1;  // [RULE_03] [RULE_04]
      end
      if (!MUX_BUS_SEL && STREAM_RATE == `SPS_RATE_8M) begin
         next_addr_valid[7] = 1'b1;  // [RULE_05] [RULE_06]
      end
   end

   assign pin_raw = {ADDR_MID_OR_SERIAL_IN_11_13,
                     ADDR_LOW_OR_SERIAL_IN_8_10,
                     SERIAL_IN7_OR_ADDR7, SERIAL_IN6_OR_ADDR6,
                     SERIAL_IN_0_TO_5};

   // Address pins are asynchronous to CLK, so they pass two flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pin_s1 <= 14'h0000;
         pin_s2 <= 14'h0000;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ADDR_VALID <= 8'h00;
         STREAM_ACTIVE <= 14'h0000;
         ADDR_BUS <= 8'h00;
      end else begin
         ADDR_VALID <= next_addr_valid;
         STREAM_ACTIVE[7:0] <= ~next_addr_valid;
         STREAM_ACTIVE[13:8] <= {6{CFG_16X8}};  // [RULE_10] [RULE_11]
         ADDR_BUS <= {pin_s2[7:6], pin_s2[13:8]} & next_addr_valid;
      end
   end

   // ------------------------------------------------------------------
   // Transfer acknowledge
   // ------------------------------------------------------------------
   // Open drain: the pin is only ever pulled low, never driven high
   assign TRANSFER_ACK_N_OUT = 1'b0;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
      end else begin
         cs_s1 <= CHIP_SELECT_N;
         cs_s2 <= cs_s1;
      end
   end

   // Held until chip select goes away so the processor sees a level
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         TRANSFER_ACK_N_OE <= 1'b0;
      end else if (cs_s2) begin
         TRANSFER_ACK_N_OE <= 1'b0;  // [RULE_01]
      end else if (XFER_DONE) begin
         TRANSFER_ACK_N_OE <= 1'b1;  // [RULE_01] [RULE_12]
      end
   end

   // ------------------------------------------------------------------
   // Link domain reset and configuration crossing
   // ------------------------------------------------------------------
   logic lrst_s1;
   logic lrst_n;
   logic [26:0] cfg_l1;
   logic [26:0] cfg_l2;
   logic [13:0] en_l;
   logic clk8_l;
   sps_rate_t rate_l;
   logic cfg16_l;

   // Reset asserts at once but releases on SER_CLK, which may stand still
   always_ff @(posedge SER_CLK or negedge NRST) begin
      if (!NRST) begin
         lrst_s1 <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_s1 <= 1'b1;
         lrst_n <= lrst_s1;
      end
   end

   // Quasi-static levels; changes are only legal between frames
   always_ff @(posedge SER_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
         cfg_l1 <= 27'h0000000;
         cfg_l2 <= 27'h0000000;
      end else begin
         cfg_l1 <= {STREAM_ACTIVE, CLK_SPEED_SEL, STREAM_RATE,
                    CFG_16X8, 9'h000};
         cfg_l2 <= cfg_l1;
      end
   end

   assign en_l = cfg_l2[26:13];
   assign clk8_l = cfg_l2[12];
   assign rate_l = cfg_l2[11:10];
   assign cfg16_l = cfg_l2[9];

   // ------------------------------------------------------------------
   // Frame pulse polarity detection
   // ------------------------------------------------------------------
   sps_fp_state_t fp_state;
   logic fp_s1;
   logic fp_s2;
   logic fp_last;
   logic [3:0] fp_stable;
   logic idle_lvl;
   logic frame_go;
   logic fp_active;

   assign fp_active = fp_s2 ^ idle_lvl;

   always_ff @(posedge SER_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
         fp_s1 <= 1'b1;
         fp_s2 <= 1'b1;
         fp_last <= 1'b1;
         fp_stable <= 4'h0;
      end else begin
         fp_s1 <= FRAME_SYNC_PULSE;
         fp_s2 <= fp_s1;
         fp_last <= fp_s2;
         if (fp_s2 != fp_last)
            fp_stable <= 4'h0;
         else if (fp_stable != `SPS_FP_STABLE)
            fp_stable <= fp_stable + 4'h1;
      end
   end

   // A long steady level is the idle level; GCI idles low
   always_ff @(posedge SER_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
         fp_state <= FP_SEEK;
         idle_lvl <= 1'b1;
         frame_go <= 1'b0;
      end else begin
         frame_go <= 1'b0;
         unique case (fp_state)
            FP_SEEK: begin
               if (fp_stable == `SPS_FP_STABLE) begin
                  idle_lvl <= fp_s2;  // [RULE_07]
                  fp_state <= FP_IDLE;
               end
            end
            FP_IDLE: begin
               if (fp_active)
                  fp_state <= FP_PULSE;
            end
            FP_PULSE: begin
               if (fp_stable == `SPS_FP_STABLE) begin
                  fp_state <= FP_SEEK;  // [RULE_07]
               end else if (!fp_active) begin
                  frame_go <= 1'b1;  // [RULE_13]
                  fp_state <= FP_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Serial sampling, per group
   // ------------------------------------------------------------------
   logic [1:0][1:0] phase;
   logic [1:0][2:0] bit_no;
   logic [1:0][6:0] chan;
   logic [1:0][1:0] span;
   logic [1:0][6:0] ch_last;
   logic [1:0] sample;
   logic [1:0] byte_end;
   logic [1:0] tog;
   logic [13:0][7:0] shreg;
   logic [13:0][7:0] hold;
   logic [1:0][6:0] hold_chan;
   logic [3:0][13:0] ser_dly;

   // Data lags the pins by as many clocks as frame pulse detection takes,
   // so bit 0 of a frame lands on the first sample after the restart
   always_ff @(posedge SER_CLK or negedge lrst_n) begin
      if (!lrst_n) begin
         ser_dly <= '0;
      end else begin
         ser_dly <= {ser_dly[2:0], pin_raw};  // [RULE_13]
      end
   end

   assign span[0] = bit_span(clk8_l, rate_l);  // [RULE_08]
   assign span[1] = bit_span(clk8_l, `SPS_RATE_2M);  // [RULE_10]
   assign ch_last[0] = last_chan(rate_l);  // [RULE_02]
   assign ch_last[1] = `SPS_LAST_CH_2M;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_grp
         assign sample[g] = (phase[g] == 2'((3'h1 << span[g]) - 3'h1));
         assign byte_end[g] = sample[g] && (bit_no[g] == `SPS_BIT_LAST);

         always_ff @(posedge SER_CLK or negedge lrst_n) begin
            if (!lrst_n) begin
               phase[g] <= 2'h0;
               bit_no[g] <= 3'h0;
               chan[g] <= 7'h00;
            end else if (frame_go) begin
               phase[g] <= 2'h0;  // [RULE_13]
               bit_no[g] <= 3'h0;
               chan[g] <= 7'h00;
            end else if (sample[g]) begin
               phase[g] <= 2'h0;
               bit_no[g] <= bit_no[g] + 3'h1;
               if (byte_end[g])
                  chan[g] <= (chan[g] == ch_last[g]) ? 7'h00 :
                             chan[g] + 7'h01;  // [RULE_02]
            end else begin
               phase[g] <= phase[g] + 2'h1;
            end
         end

         always_ff @(posedge SER_CLK or negedge lrst_n) begin
            if (!lrst_n) begin
               tog[g] <= 1'b0;
               hold_chan[g] <= 7'h00;
            end else if (byte_end[g]) begin
               // The restart edge also carries the last bit of the frame
               tog[g] <= ~tog[g];
               hold_chan[g] <= chan[g];
            end
         end
      end

      for (genvar i = 0; i < `SPS_NUM_STREAMS; i++) begin : g_str
         localparam int G = (i < `SPS_NUM_MAIN) ? 0 : 1;
         // Serial data is launched on SER_CLK, so no synchroniser here
         always_ff @(posedge SER_CLK or negedge lrst_n) begin
            if (!lrst_n) begin
               shreg[i] <= 8'h00;
               hold[i] <= 8'h00;
            end else if (sample[G]) begin
               shreg[i] <= {shreg[i][6:0], ser_dly[3][i]};  // [RULE_13]
               if (byte_end[G])
                  hold[i] <= {shreg[i][6:0], ser_dly[3][i]} & {8{en_l[i]}};
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Byte hand-off to CLK; holds stay put for a whole channel time
   // ------------------------------------------------------------------
   logic [1:0] tg_s1;
   logic [1:0] tg_s2;
   logic [1:0] tg_s3;
   logic gci_s1;
   logic gci_s2;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tg_s1 <= 2'h0;
         tg_s2 <= 2'h0;
         tg_s3 <= 2'h0;
         gci_s1 <= 1'b0;
         gci_s2 <= 1'b0;
      end else begin
         tg_s1 <= tog;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
         gci_s1 <= ~idle_lvl;
         gci_s2 <= gci_s1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         RX_DATA <= 112'h0;
         RX_CHAN <= 14'h0000;
         RX_VALID <= 2'h0;
         GCI_MODE <= 1'b0;
      end else begin
         RX_VALID <= tg_s2 ^ tg_s3;
         GCI_MODE <= gci_s2;  // [RULE_07]
         if (tg_s2[0] ^ tg_s3[0]) begin
            RX_DATA[63:0] <= hold[7:0];
            RX_CHAN[6:0] <= hold_chan[0];
         end
         if (tg_s2[1] ^ tg_s3[1]) begin
            RX_DATA[111:64] <= hold[13:8];
            RX_CHAN[13:7] <= hold_chan[1];
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence s_cs_done;
      !cs_s2 && XFER_DONE;
   endsequence

   chk_ack_pull: assert property (@(posedge CLK) disable iff (!NRST)
      s_cs_done |=> TRANSFER_ACK_N_OE)  // [RULE_01]
      else $error("ack not pulled low after transfer");
   chk_ack_release: assert property (@(posedge CLK) disable iff (!NRST)
      cs_s2 |=> !TRANSFER_ACK_N_OE)  // [RULE_01]
      else $error("ack not released");
   chk_addr6_role: assert property (@(posedge CLK) disable iff (!NRST)
      (!MUX_BUS_SEL && !CFG_8X4 && STREAM_RATE != `SPS_RATE_2M)
      |=> ADDR_VALID[6] && !STREAM_ACTIVE[6])  // [RULE_03]
      else $error("input-6 pin not address");
   chk_stream6_role: assert property (@(posedge CLK) disable iff (!NRST)
      (MUX_BUS_SEL || CFG_8X4 || STREAM_RATE == `SPS_RATE_2M)
      |=> STREAM_ACTIVE[6])  // [RULE_04]
      else $error("input-6 pin not stream");
   chk_addr7_role: assert property (@(posedge CLK) disable iff (!NRST)
      (!MUX_BUS_SEL && STREAM_RATE == `SPS_RATE_8M) |=> ADDR_VALID[7])
      // [RULE_05]
      else $error("input-7 pin not address");
   chk_stream7_role: assert property (@(posedge CLK) disable iff (!NRST)
      (MUX_BUS_SEL || STREAM_RATE != `SPS_RATE_8M) |=> STREAM_ACTIVE[7])
      // [RULE_06]
      else $error("input-7 pin not stream");
   chk_addr_low: assert property (@(posedge CLK) disable iff (!NRST)
      (!MUX_BUS_SEL && !CFG_16X8) |=> ADDR_VALID[2:0] == 3'h7)  // [RULE_09]
      else $error("low address pins not address");
   chk_hi_streams: assert property (@(posedge CLK) disable iff (!NRST)
      CFG_16X8 |=> STREAM_ACTIVE[13:8] == 6'h3f && ADDR_VALID[5:0] == 6'h00)
      // [RULE_10] [RULE_11]
      else $error("16x8 pins not streams");
   chk_chan_wrap: assert property (@(posedge SER_CLK) disable iff (!lrst_n)
      (byte_end[0] && !frame_go && chan[0] == ch_last[0]) |=> chan[0] == 7'h00)
      // [RULE_02]
      else $error("channel count did not wrap");
   chk_frame_restart: assert property (@(posedge SER_CLK)
      disable iff (!lrst_n)
      frame_go |=> chan == 14'h0000 && bit_no == 6'h00)  // [RULE_13]
      else $error("counters not restarted at frame");
   chk_span_8m: assert property (@(posedge SER_CLK) disable iff (!lrst_n)
      (clk8_l && rate_l == `SPS_RATE_2M) |-> span[0] == 2'h2)  // [RULE_08]
      else $error("bit span wrong for 8 MHz clock");
   chk_fp_idle: assert property (@(posedge SER_CLK) disable iff (!lrst_n)
      (fp_state == FP_SEEK && fp_stable == `SPS_FP_STABLE)
      |=> idle_lvl == $past(fp_s2))  // [RULE_07]
      else $error("frame pulse idle level not caught");

endmodule
`default_nettype wire

// ==== verif/sps_far_end.sv ====
/*
 * Far-end model: backplane devices sending framed serial streams and the
 * frame pulse, one bit per one or two serial clocks, MSB first.
 * Assumes a free-running serial clock from the bench, since backplane
 * clocks run continuously; lines change on its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sps_far_end (
   // Link clock
   input wire logic ser_clk,
   // Frame setup
   input wire logic gci,
   input wire logic [6:0] last_ch,
   input wire logic two_clk,
   // Pins
   output logic frame_pulse,
   output logic [13:0] ser_data
);
   logic [11:0] cnt = 12'h0;
   logic [11:0] total;
   logic [9:0] idx;
   logic [6:0] ch;

   function automatic logic [7:0] byte_of(input int s, input logic [6:0] c);
      return 8'(int'(c) * 5 + s * 29);
   endfunction

   // ----------------------------------------------------------------
   // Frame timing
   // ----------------------------------------------------------------
   // 32, 64 or 128 channels of 8 bits per frame
   assign total = ({5'h0, last_ch} + 12'h1) * (two_clk ? 12'h10 : 12'h8);
   assign idx = 10'(two_clk ? cnt >> 1 : cnt);
   assign ch = idx[9:3];
   always @(negedge ser_clk) begin
      cnt <= (cnt >= total - 12'h1) ? 12'h0 : cnt + 12'h1;
   end
   // Pulse fills the clock ahead of bit 0, low or high by format
   assign frame_pulse = (cnt == total - 12'h1) ^ ~gci;

   // Streams 8-13 share the clock; bench runs them at 2.048 in the 16x8 run
   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      for (int s = 0; s < 14; s++) begin
         b = byte_of(s, ch);
         ser_data[s] = b[3'h7 - idx[2:0]];
      end
   end
endmodule
`default_nettype wire

// ==== verif/sps_pin_front_test.sv ====
/*
 * Self-checking bench: pin role decode, acknowledge and serial receive.
 * Assumes sps_far_end drives the streams; the bench acts as processor.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sps_pin_map.svh"
module sps_pin_front_test;
   import sps_pin_pkg::*;
   logic clk = 1'h0;
   logic ser_clk = 1'h0;
   logic nrst = 1'h0;
   logic mux_bus_sel = 1'h0;
   logic [1:0] stream_rate = 2'h0;
   logic clk_speed_sel = 1'h0;
   logic cfg_8x4 = 1'h0;
   logic cfg_16x8 = 1'h0;
   logic cs_n = 1'h1;
   logic xfer_done = 1'h0;
   logic ser_on = 1'h0;
   logic [7:0] addr_pins = 8'h0;
   logic gci = 1'h0;
   logic [6:0] last_ch = 7'h7f;
   logic two_clk = 1'h0;
   logic mon_on = 1'h0;
   logic ack_out, ack_oe, gci_mode, frame_pulse;
   logic [7:0] addr_bus, addr_valid;
   logic [13:0] stream_active, rx_chan, ser_data;
   logic [111:0] rx_data;
   logic [1:0] rx_valid;
   int n_mismatch = 0;
   int n_compared = 0;
   int seen [2];
   int prev [2];

   always #5 clk = ~clk;
   initial begin
      #3;
      forever #24 ser_clk = ~ser_clk;
   end

   sps_pin_front i_sps_pin_front (.CLK(clk), .NRST(nrst), .SER_CLK(ser_clk),
      .FRAME_SYNC_PULSE(frame_pulse), .SERIAL_IN_0_TO_5(ser_data[5:0]),
      .SERIAL_IN6_OR_ADDR6(ser_on ? ser_data[6] : addr_pins[6]),
      .SERIAL_IN7_OR_ADDR7(ser_on ? ser_data[7] : addr_pins[7]),
      .ADDR_LOW_OR_SERIAL_IN_8_10(ser_on ? ser_data[10:8] : addr_pins[2:0]),
      .ADDR_MID_OR_SERIAL_IN_11_13(ser_on ? ser_data[13:11] : addr_pins[5:3]),
      .MUX_BUS_SEL(mux_bus_sel), .STREAM_RATE(stream_rate),
      .CLK_SPEED_SEL(clk_speed_sel), .CFG_8X4(cfg_8x4), .CFG_16X8(cfg_16x8),
      .CHIP_SELECT_N(cs_n), .XFER_DONE(xfer_done),
      .TRANSFER_ACK_N_OUT(ack_out), .TRANSFER_ACK_N_OE(ack_oe),
      .ADDR_BUS(addr_bus), .ADDR_VALID(addr_valid),
      .STREAM_ACTIVE(stream_active), .RX_DATA(rx_data), .RX_CHAN(rx_chan),
      .RX_VALID(rx_valid), .GCI_MODE(gci_mode));

   sps_far_end i_sps_far_end (.ser_clk(ser_clk), .gci(gci),
      .last_ch(last_ch), .two_clk(two_clk), .frame_pulse(frame_pulse),
      .ser_data(ser_data));

   // ----------------------------------------------------------------
   // Checking and verdict
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] got,
                        input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic logic [7:0] exp_byte(input int s, input logic [6:0] c);
      return 8'(int'(c) * 5 + s * 29);
   endfunction

   // ----------------------------------------------------------------
   // Receive monitor: channel order and byte content per group
   // ----------------------------------------------------------------
   task automatic rx_group(input int g, input int s0, input int s1,
                           input int wrap);
      logic [6:0] c;
      c = g ? rx_chan[13:7] : rx_chan[6:0];
      if (seen[g] > 0) begin
         check("rx_chan", 32'(c), 32'((prev[g] + 1) % wrap));
      end
      for (int s = s0; s <= s1; s++) begin
         check("rx_byte", 32'(rx_data[8*s +: 8]), 32'(exp_byte(s, c)));
      end
      prev[g] = int'(c);
      seen[g]++;
   endtask

   always @(posedge clk) begin
      if (!mon_on) begin
         seen = '{0, 0};
      end else begin
         if (rx_valid[0] === 1'h1) begin
            rx_group(0, 0, 7, int'(last_ch) + 1);
         end
         if (rx_valid[1] === 1'h1 && cfg_16x8 === 1'h1) begin
            rx_group(1, 8, 13, 32);
         end
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic dec(input logic mux, input logic [1:0] rate,
                      input logic c84, input logic c168, input logic [7:0] m,
                      input logic [7:0] av, input logic [7:0] sa);
      @(posedge clk);
      mux_bus_sel <= mux;
      stream_rate <= rate;
      cfg_8x4 <= c84;
      cfg_16x8 <= c168;
      addr_pins <= 8'ha5;
      repeat (4) @(posedge clk);
      #1;
      check("addr_valid", 32'(addr_valid & m), 32'(av));
      check("stream_active", 32'(stream_active[13:6] & {6'h3f, m[7:6]}),
            32'(sa));
      check("addr_bus", 32'(addr_bus & m), 32'(8'ha5 & av));
   endtask

   task automatic test_ack();
      int n;
      @(posedge clk);
      xfer_done <= 1'h1;
      @(posedge clk);
      xfer_done <= 1'h0;
      repeat (4) @(posedge clk);
      check("ack_refused", 32'(ack_oe), 32'h0);
      cs_n <= 1'h0;
      repeat (3) @(posedge clk);
      xfer_done <= 1'h1;
      @(posedge clk);
      xfer_done <= 1'h0;
      n = 0;
      while (ack_oe !== 1'h1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      #1;
      check("ack_held", 32'(ack_oe), 32'h1);
      check("ack_level", 32'(ack_out), 32'h0);
      @(posedge clk);
      cs_n <= 1'h1;
      n = 0;
      while (ack_oe !== 1'h0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      check("ack_release", 32'(ack_oe), 32'h0);
   endtask

   task automatic test_serial(input logic g, input logic [1:0] rate,
                              input logic spd, input logic c168,
                              input logic [6:0] last, input logic two);
      int frame;
      frame = (int'(last) + 1) * 8 * (two ? 2 : 1) * 48 / 10 + 40;
      @(posedge clk);
      ser_on <= 1'h1;
      gci <= g;
      last_ch <= last;
      two_clk <= two;
      stream_rate <= rate;
      clk_speed_sel <= spd;
      cfg_16x8 <= c168;
      cfg_8x4 <= 1'h0;
      mux_bus_sel <= 1'h1;
      repeat (2 * frame) @(posedge clk);
      mon_on <= 1'h1;
      repeat (frame) @(posedge clk);
      mon_on <= 1'h0;
      check("gci_mode", 32'(gci_mode), 32'(g));
      check("rx_count0", 32'(seen[0] >= int'(last) + 1), 32'h1);
      if (c168) begin
         check("rx_count1", 32'(seen[1] >= 32), 32'h1);
      end
   endtask

   initial begin
      repeat (3) @(posedge ser_clk);
      @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      dec(1'h0, `SPS_RATE_8M, 1'h0, 1'h0, 8'hff, 8'hff, 8'h00);
      dec(1'h0, `SPS_RATE_4M, 1'h0, 1'h0, 8'h7f, 8'h7f, 8'h00);
      dec(1'h0, `SPS_RATE_4M, 1'h1, 1'h0, 8'hff, 8'h3f, 8'h03);
      dec(1'h0, `SPS_RATE_2M, 1'h0, 1'h0, 8'hff, 8'h3f, 8'h03);
      dec(1'h1, `SPS_RATE_8M, 1'h0, 1'h0, 8'hff, 8'h00, 8'h03);
      dec(1'h0, `SPS_RATE_2M, 1'h0, 1'h1, 8'hff, 8'h00, 8'hff);
      test_ack();
      test_serial(1'h0, `SPS_RATE_8M, `SPS_CLK_8M, 1'h0, 7'h7f, 1'h0);
      test_serial(1'h1, `SPS_RATE_4M, `SPS_CLK_8M, 1'h0, 7'h3f, 1'h1);
      test_serial(1'h0, `SPS_RATE_2M, `SPS_CLK_4M, 1'h1, 7'h1f, 1'h1);
      print_verdict();
   end

   // Whole run needs about 40k cycles; this leaves generous slack
   initial begin
      #900000;
      n_mismatch++;
      print_verdict();
   end
endmodule
`default_nettype wire
